// ---- sim/lane_map_capture_assertions.sv ----
// concurrent checks on the lane map and arrival capture ports
`timescale 1ns/10ps
module lane_map_capture_assertions (
	input wire logic                   clk_sys,
	input wire logic                   srst,
	input wire lane_map_pkg::reg_req_t reg_req,
	input wire logic [7:0]             reg_rdata,
	input wire logic [15:0]            logical_lane_ready,
	input wire logic                   buffer_release_attempt,
	input wire logic                   link_enable_control,
	input wire logic                   link_restart_control,
	input wire logic                   arrival_capture_valid
);
	import lane_map_pkg::*;
	logic go;
	logic held;
	assign go   = buffer_release_attempt && (&logical_lane_ready);
	assign held = !link_enable_control || link_restart_control;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	chk_hold_clears: assert property (held |-> !arrival_capture_valid)
		else $error("ready flag set while link held");
	chk_capture_rise: assert property (go && !held && !arrival_capture_valid
		&& $past(!held) |=> arrival_capture_valid)
		else $error("release attempt did not capture");
	chk_rise_cause: assert property ($rose(arrival_capture_valid) |-> $past(go))
		else $error("ready flag rose without attempt");
	chk_valid_stays: assert property (arrival_capture_valid |=> arrival_capture_valid || held)
		else $error("ready flag dropped on its own");
	chk_not_ready: assert property (buffer_release_attempt && !(&logical_lane_ready)
		&& !arrival_capture_valid |=> !arrival_capture_valid)
		else $error("capture with a lane not ready");
	chk_status_read: assert property ($past(reg_req.rd) && $past(reg_req.addr) == OFS_ARSTAT
		|-> reg_rdata == {7'h00, $past(arrival_capture_valid)})
		else $error("status read wrong");
	chk_arr_range: assert property ($past(reg_req.rd) && $past(reg_req.addr[8:4]) == 5'h14
		|-> reg_rdata[7:6] == 2'h0)
		else $error("arrival read out of range");
	chk_sel_width: assert property ($past(reg_req.rd) && $past(reg_req.addr[8:4]) == 5'h13
		|-> reg_rdata[7:4] == 4'h0)
		else $error("select read wider than four bits");

	cover property (go ##1 arrival_capture_valid);
	cover property ($fell(arrival_capture_valid));
	cover property (buffer_release_attempt && !(&logical_lane_ready));
endmodule

// ---- sim/lane_tx_model.sv ----
// far-side transmitter: lane words, sysref aligned boundary, per-lane arrival marks
`timescale 1ns/10ps
module lane_tx_model (
	input  wire logic                clk_sys,
	input  wire logic                shift,
	output lane_map_pkg::lane_bus_t  phys_lane_data,
	output logic [15:0]              logical_arrival_mark,
	output logic                     lemc_boundary
);
	import lane_map_pkg::*;
	logic [6:0] ph;
	initial begin
		ph = 7'h00;
		phys_lane_data = '0;
		logical_arrival_mark = 16'h0000;
		lemc_boundary = 1'b0;
	end
	// lane 15 arrives late on purpose, past the 63 ceiling
	always @(posedge clk_sys) begin
		ph <= (ph == 7'h4f) ? 7'h00 : ph + 7'h01;
		lemc_boundary <= (ph == 7'h4f);
		for (int l = 0; l < NUM_LANES; l++) begin
			phys_lane_data[l] <= {l[3:0], 21'h0, ph};
			logical_arrival_mark[l] <= ph == 7'(l == 15 ? 70 : l * 4) + {6'h00, shift};
		end
	end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the lane map and arrival capture block
`timescale 1ns/10ps
module tb;
	import lane_map_pkg::*;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	reg_req_t    req = '0;
	logic [7:0]  rdata;
	lane_bus_t   phys, logical, prev;
	logic [15:0] rdy = 16'h0000, mark, flp = 16'h0000;
	logic        lemc, rel = 1'b0, en, rs, valid, irq, shift = 1'b0;
	lane_sel_t   sel [NUM_LANES];
	int          mismatches = 0, cmp_count = 0;

	lane_map_capture uut (.clk_sys, .srst, .reg_req(req), .reg_rdata(rdata),
		.phys_lane_data(phys), .logical_lane_data(logical), .logical_lane_ready(rdy),
		.logical_arrival_mark(mark), .lemc_boundary(lemc), .buffer_release_attempt(rel),
		.link_enable_control(en), .link_restart_control(rs), .arrival_capture_valid(valid),
		.irq);
	lane_tx_model far (.clk_sys, .shift, .phys_lane_data(phys), .logical_arrival_mark(mark),
		.lemc_boundary(lemc));

	initial forever #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) prev <= phys;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %0t ns seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req <= '0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req <= '0;
		#1 chk(rdata, e);
	endtask
	task automatic dchk();
		for (int n = 0; n < 3; n++) begin
			@(posedge clk_sys);
			#1;
			for (int l = 0; l < NUM_LANES; l++)
				chk(logical[l], prev[sel[l]] ^ {32{flp[sel[l]]}});
		end
	endtask
	task automatic fire(input logic [15:0] r);
		repeat (170) @(posedge clk_sys);
		rdy <= r;
		rel <= 1'b1;
		@(posedge clk_sys);
		rel <= 1'b0;
		#1;
	endtask
	task automatic arr(input int s);
		int v;
		for (int l = 0; l < NUM_LANES; l++) begin
			v = (l == 15 ? 70 : l * 4) + s;
			rd(OFS_ARR_BASE + 9'(l), 8'(v > 63 ? 63 : v));
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// generous margin over roughly 900 cycles of tests
	initial begin
		#20000;
		mismatches++;
		complete_run();
	end

	initial begin
		foreach (sel[l]) sel[l] = 4'(l);
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		for (int l = 0; l < NUM_LANES; l++)
			rd(OFS_SEL_BASE + 9'(l), 8'(l));
		rd(OFS_ARSTAT, 8'h00);
		rd(OFS_INV_HI, 8'h00);
		chk({rs, en, irq, valid}, 4'h0);
		dchk();
		$display("reset values done");
		for (int l = 0; l < NUM_LANES; l++) begin
			sel[l] = 4'(15 - l);
			wr(OFS_SEL_BASE + 9'(l), 8'(15 - l));
		end
		flp = 16'h81a5;
		wr(OFS_INV_LO, 8'ha5);
		wr(OFS_INV_HI, 8'h81);
		rd(OFS_SEL_BASE + 9'h3, 8'h0c);
		rd(OFS_INV_HI, 8'h81);
		dchk();
		wr(OFS_ARSTAT, 8'hff);
		wr(OFS_ARR_BASE, 8'hff);
		rd(OFS_ARSTAT, 8'h00);
		rd(OFS_ARR_BASE, 8'h00);
		rd(9'h100, 8'h00);
		$display("lane map done");
		wr(OFS_IRQ_ENABLE, 8'h07);
		wr(OFS_LINK_CTRL, 8'h01);
		rd(OFS_LINK_CTRL, 8'h01);
		rd(OFS_IRQ_ENABLE, 8'h07);
		fire(16'h7fff);
		chk(valid, 1'b0);
		chk(irq, 1'b1);
		rd(OFS_IRQ_STATUS, 8'h04);
		wr(OFS_IRQ_CLEAR, 8'h04);
		fire(16'hffff);
		chk(valid, 1'b1);
		rd(OFS_ARSTAT, 8'h01);
		arr(0);
		rd(OFS_IRQ_STATUS, 8'h01);
		shift <= 1'b1;
		fire(16'hffff);
		arr(0);
		$display("capture done");
		wr(OFS_IRQ_CLEAR, 8'h01);
		#1 chk(irq, 1'b0);
		wr(OFS_LINK_CTRL, 8'h03);
		#1 chk(valid, 1'b0);
		chk({rs, en}, 2'h3);
		wr(OFS_LINK_CTRL, 8'h01);
		rd(OFS_IRQ_STATUS, 8'h02);
		chk(irq, 1'b1);
		wr(OFS_IRQ_ENABLE, 8'h00);
		#1 chk(irq, 1'b0);
		fire(16'hffff);
		chk(valid, 1'b1);
		arr(1);
		wr(OFS_LINK_CTRL, 8'h00);
		#1 chk(valid, 1'b0);
		chk({rs, en}, 2'h0);
		rd(OFS_ARSTAT, 8'h00);
		$display("hold done");
		complete_run();
	end
endmodule

bind lane_map_capture lane_map_capture_assertions chk_i (.clk_sys, .srst, .reg_req,
	.reg_rdata, .logical_lane_ready, .buffer_release_attempt, .link_enable_control,
	.link_restart_control, .arrival_capture_valid);

// ---- verilog/lane_map_capture.sv ----
// lane polarity, lane crossbar, arrival time capture and register file
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
// Operation
// - ready flag rises once arrival times are captured and readable
// - capture happens when all lanes ready and buffer release is attempted
// - ready flag clears while link disabled or restart control is set
// - polarity bit set inverts that physical lane's bitstream
// - each logical lane takes data from the physical lane in its select
// - sixteen select registers, consecutive, logical lane zero lowest
// - after reset each select equals its own lane index
// - arrival time measured against the sysref aligned multiframe clock
module lane_map_capture (
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	input  wire lane_map_pkg::reg_req_t reg_req,
	output      logic [7:0]            reg_rdata,
	input  wire lane_map_pkg::lane_bus_t phys_lane_data,
	output      lane_map_pkg::lane_bus_t logical_lane_data,
	input  wire logic [15:0]           logical_lane_ready,
	input  wire logic [15:0]           logical_arrival_mark,
	input  wire logic                  lemc_boundary,
	input  wire logic                  buffer_release_attempt,
	output      logic                  link_enable_control,
	output      logic                  link_restart_control,
	output      logic                  arrival_capture_valid,
	output      logic                  irq
);
	import lane_map_pkg::*;

	// register state
	logic [NUM_LANES-1:0]  physical_lane_polarity_flip;
	lane_sel_t             lane_sel [NUM_LANES];
	arr_time_t             lane_arrival_time [NUM_LANES];
	arr_time_t             arrival_live [NUM_LANES];
	arr_time_t             lemc_count;
	logic [NUM_EVENTS-1:0] irq_status;
	logic [NUM_EVENTS-1:0] irq_enable;
	cap_state_t            cap_state;
	cap_state_t            next_cap_state;

	// address decode
	wire logic                  hit_arstat;
	wire logic                  hit_inv_lo;
	wire logic                  hit_inv_hi;
	wire logic                  hit_sel;
	wire logic                  hit_arr;
	wire logic                  hit_irq_status;
	wire logic                  hit_irq_clear;
	wire logic                  hit_irq_enable;
	wire logic                  hit_link_ctrl;
	wire logic [SEL_W-1:0]      reg_index;
	wire logic                  wr_sel;
	wire logic                  wr_inv_lo;
	wire logic                  wr_inv_hi;
	wire logic                  wr_irq_clear;
	wire logic                  wr_irq_enable;
	wire logic                  wr_link_ctrl;

	assign reg_index      = reg_req.addr[SEL_W-1:0];
	assign hit_arstat     = reg_req.addr == OFS_ARSTAT;
	assign hit_inv_lo     = reg_req.addr == OFS_INV_LO;
	assign hit_inv_hi     = reg_req.addr == OFS_INV_HI;
	// one register per logical lane, lane zero at the base
	assign hit_sel        = reg_req.addr[ADDR_W-1:SEL_W] == OFS_SEL_BASE[ADDR_W-1:SEL_W];
	assign hit_arr        = reg_req.addr[ADDR_W-1:SEL_W] == OFS_ARR_BASE[ADDR_W-1:SEL_W];
	assign hit_irq_status = reg_req.addr == OFS_IRQ_STATUS;
	assign hit_irq_clear  = reg_req.addr == OFS_IRQ_CLEAR;
	assign hit_irq_enable = reg_req.addr == OFS_IRQ_ENABLE;
	assign hit_link_ctrl  = reg_req.addr == OFS_LINK_CTRL;

	assign wr_sel        = reg_req.wr && hit_sel;
	assign wr_inv_lo     = reg_req.wr && hit_inv_lo;
	assign wr_inv_hi     = reg_req.wr && hit_inv_hi;
	assign wr_irq_clear  = reg_req.wr && hit_irq_clear;
	assign wr_irq_enable = reg_req.wr && hit_irq_enable;
	assign wr_link_ctrl  = reg_req.wr && hit_link_ctrl;

	// link state derived from control
	wire logic link_held;
	wire logic all_lanes_ready;
	wire logic capture_now;
	wire logic refused_now;
	wire logic flag_lost;
	wire logic st_armed;
	wire logic st_done;

	assign link_held       = !link_enable_control || link_restart_control;
	assign all_lanes_ready = &logical_lane_ready;
	// one-hot state decode, shared by every capture term
	assign st_armed        = cap_state == CAP_ARMED;
	assign st_done         = cap_state == CAP_DONE;
	// a second attempt after capture must not disturb the held values
	assign capture_now     = buffer_release_attempt && all_lanes_ready && !link_held
	                         && st_armed;
	assign refused_now     = buffer_release_attempt && !all_lanes_ready && !link_held
	                         && st_armed;
	assign flag_lost       = link_held && st_done;

	// polarity ahead of the crossbar
	lane_bus_t phys_fixed;

	genvar p;
	generate
		for (p = 0; p < NUM_LANES; p++) begin : g_phys
			// follows the physical pair, wherever it is routed
			assign phys_fixed[p] = phys_lane_data[p]
			                       ^ {LANE_W{physical_lane_polarity_flip[p]}};
		end
	endgenerate

	// crossbar
	// registered per logical lane: one cycle from physical input to output
	genvar l;
	generate
		for (l = 0; l < NUM_LANES; l++) begin : g_route
			lane_route u_route (
				.clk_sys      (clk_sys),
				.srst         (srst),
				.sel          (lane_sel[l]),
				.phys_data    (phys_fixed),
				.logical_data (logical_lane_data[l])
			);
		end
	endgenerate

	// select registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				lane_sel[i] <= SEL_W'(i);
			end
		end else if (wr_sel) begin
			// not blocked while the link runs; changing live remaps traffic
			lane_sel[reg_index] <= reg_req.wdata[SEL_W-1:0];
		end
	end

	// polarity register, two byte lanes
	// byte writes touch only their own half
	wire logic [NUM_LANES-1:0] next_flip;

	assign next_flip[7:0]  = wr_inv_lo ? reg_req.wdata : physical_lane_polarity_flip[7:0];
	assign next_flip[15:8] = wr_inv_hi ? reg_req.wdata : physical_lane_polarity_flip[15:8];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			physical_lane_polarity_flip <= INV_RESET;
		end else begin
			physical_lane_polarity_flip <= next_flip;
		end
	end

	// link control register; restart is a plain bit that software pulses
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			link_enable_control <= CTRL_RESET[CTRL_EN_BIT];
		end else if (wr_link_ctrl) begin
			link_enable_control <= reg_req.wdata[CTRL_EN_BIT];
		end
	end

	// a hold drops the ready flag at once, with no wait for the next edge
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			link_restart_control <= CTRL_RESET[CTRL_RST_BIT];
		end else if (wr_link_ctrl) begin
			link_restart_control <= reg_req.wdata[CTRL_RST_BIT];
		end
	end

	// multiframe phase counter; saturates so long frames still fit six bits
	wire arr_time_t next_lemc_count;
	wire logic      lemc_at_max;

	assign lemc_at_max     = lemc_count == ARR_MAX;
	assign next_lemc_count = lemc_boundary ? ARR_RESET
	                       : lemc_at_max ? ARR_MAX
	                       : arr_time_t'(lemc_count + 1'b1);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lemc_count <= ARR_RESET;
		end else begin
			lemc_count <= next_lemc_count;
		end
	end

	// per logical lane live arrival time, frozen once captured
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				arrival_live[i] <= ARR_RESET;
			end
		end else if (link_held) begin
			// stale marks from before a hold must not reach the next capture
			for (int i = 0; i < NUM_LANES; i++) begin
				arrival_live[i] <= ARR_RESET;
			end
		end else if (st_armed) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				if (logical_arrival_mark[i]) begin
					arrival_live[i] <= lemc_count;
				end
			end
		end
	end

	// snapshot of all lanes at once
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				lane_arrival_time[i] <= ARR_RESET;
			end
		end else if (capture_now) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				lane_arrival_time[i] <= arrival_live[i];
			end
		end
	end

	// capture sequence
	// re-arms only once the hold ends, so a restart pulse gives a fresh capture
	always_comb begin
		next_cap_state = cap_state;
		unique case (cap_state)
			CAP_IDLE: begin
				if (!link_held) begin
					next_cap_state = CAP_ARMED;
				end
			end
			CAP_ARMED: begin
				if (link_held) begin
					next_cap_state = CAP_IDLE;
				end else if (capture_now) begin
					next_cap_state = CAP_DONE;
				end
			end
			CAP_DONE: begin
				if (link_held) begin
					next_cap_state = CAP_IDLE;
				end
			end
			default: begin
				next_cap_state = CAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cap_state <= CAP_IDLE;
		end else begin
			cap_state <= next_cap_state;
		end
	end

	// flag holds only in the done state and drops the cycle the link is held
	assign arrival_capture_valid = st_done && !link_held;

	// interrupt status, set beats a simultaneous clear
	wire logic [NUM_EVENTS-1:0] events;
	wire logic [NUM_EVENTS-1:0] clear_mask;
	wire logic [NUM_EVENTS-1:0] next_irq_status;
	wire logic [NUM_EVENTS-1:0] irq_pending;

	assign events[EV_CAPTURE_BIT] = capture_now;
	assign events[EV_LOST_BIT]    = flag_lost;
	assign events[EV_REFUSED_BIT] = refused_now;
	assign clear_mask             = wr_irq_clear ? reg_req.wdata[NUM_EVENTS-1:0] : '0;
	assign next_irq_status        = (irq_status & ~clear_mask) | events;
	// enable gates only the output; events keep landing in status
	assign irq_pending            = irq_status & irq_enable;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_enable <= IRQ_EN_RESET;
		end else if (wr_irq_enable) begin
			irq_enable <= reg_req.wdata[NUM_EVENTS-1:0];
		end
	end

	assign irq = |irq_pending;

	// read selection
	wire logic [7:0] rd_arstat;
	wire logic [7:0] rd_sel;
	wire logic [7:0] rd_arr;
	wire logic [7:0] rd_ctrl;
	wire logic [7:0] rd_inv_lo;
	wire logic [7:0] rd_inv_hi;
	wire logic [7:0] rd_irq_status;
	wire logic [7:0] rd_irq_enable;
	wire logic [7:0] rd_mux;

	// upper bits forced to zero, writes there are dropped
	assign rd_arstat = {7'h00, arrival_capture_valid};
	assign rd_sel    = {4'h0, lane_sel[reg_index]};
	assign rd_arr    = {2'h0, lane_arrival_time[reg_index]};
	assign rd_ctrl   = {6'h00, link_restart_control, link_enable_control};
	// interrupt bits packed low, unused upper bits read zero
	assign rd_inv_lo     = physical_lane_polarity_flip[7:0];
	assign rd_inv_hi     = physical_lane_polarity_flip[15:8];
	assign rd_irq_status = {5'h00, irq_status};
	assign rd_irq_enable = {5'h00, irq_enable};

	assign rd_mux = hit_arstat     ? rd_arstat
	              : hit_inv_lo     ? rd_inv_lo
	              : hit_inv_hi     ? rd_inv_hi
	              : hit_sel        ? rd_sel
	              : hit_arr        ? rd_arr
	              : hit_irq_status ? rd_irq_status
	              : hit_irq_enable ? rd_irq_enable
	              : hit_link_ctrl  ? rd_ctrl
	              : 8'h00;

	// data stands only in the cycle after the read strobe
	wire logic [7:0] next_reg_rdata;

	assign next_reg_rdata = reg_req.rd ? rd_mux : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

endmodule

// ---- verilog/lane_map_pkg.sv ----
// shared constants and types for the lane map and arrival capture block
package lane_map_pkg;

	// geometry
	localparam int NUM_LANES = 16;
	localparam int LANE_W    = 32;
	localparam int SEL_W     = 4;
	localparam int ARR_W     = 6;
	localparam int ADDR_W    = 9;
	localparam int DATA_W    = 8;

	// register offsets, byte addressed
	localparam logic [ADDR_W-1:0] OFS_ARSTAT     = 9'h12c;
	localparam logic [ADDR_W-1:0] OFS_INV_LO     = 9'h12e;
	localparam logic [ADDR_W-1:0] OFS_INV_HI     = 9'h12f;
	localparam logic [ADDR_W-1:0] OFS_SEL_BASE   = 9'h130;
	localparam logic [ADDR_W-1:0] OFS_ARR_BASE   = 9'h140;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 9'h180;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 9'h181;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 9'h182;
	localparam logic [ADDR_W-1:0] OFS_LINK_CTRL  = 9'h183;

	// field positions
	localparam int ARSTAT_RDY_BIT = 0;
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_RST_BIT   = 1;
	localparam int EV_CAPTURE_BIT = 0;
	localparam int EV_LOST_BIT    = 1;
	localparam int EV_REFUSED_BIT = 2;
	localparam int NUM_EVENTS     = 3;

	// reset values
	localparam logic [NUM_LANES-1:0]  INV_RESET     = 16'h0000;
	localparam logic [1:0]            CTRL_RESET    = 2'h0;
	localparam logic [NUM_EVENTS-1:0] IRQ_EN_RESET  = 3'h0;
	localparam logic [ARR_W-1:0]      ARR_RESET     = 6'h00;
	localparam logic [ARR_W-1:0]      ARR_MAX       = 6'h3f;

	// arrival capture states
	typedef enum logic [2:0] {
		CAP_IDLE  = 3'b001,
		CAP_ARMED = 3'b010,
		CAP_DONE  = 3'b100
	} cap_state_t;

	typedef logic [LANE_W-1:0] lane_word_t;
	typedef lane_word_t [NUM_LANES-1:0] lane_bus_t;
	typedef logic [SEL_W-1:0] lane_sel_t;
	typedef logic [ARR_W-1:0] arr_time_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

endpackage

// ---- verilog/lane_route.sv ----
// one crossbar output: picks a physical lane for one logical lane
`timescale 1ns/10ps
module lane_route (
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	input  wire lane_map_pkg::lane_sel_t  sel,
	input  wire lane_map_pkg::lane_bus_t  phys_data,
	output      lane_map_pkg::lane_word_t logical_data
);
	import lane_map_pkg::*;

	wire lane_word_t picked;

	assign picked = phys_data[sel];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			logical_data <= '0;
		end else begin
			logical_data <= picked;
		end
	end

endmodule
